// [logic/irq_seq_defines.vh]
`ifndef IRQ_SEQ_DEFINES_VH
`define IRQ_SEQ_DEFINES_VH

// register indices; byte address is four times the index
`define PORT_D_IDX          10'h003
`define TIMER_CTRL_IDX      10'h009
`define MISC_EDGE_IDX       10'h00A
`define PORT_D_ADDR         12'h00C
`define TIMER_CTRL_ADDR     12'h024
`define MISC_EDGE_ADDR      12'h028

// misc_edge_reg fields
`define MISC_REQ_BIT        7
`define MISC_MASK_BIT       6
`define MISC_UNUSED_VAL     6'h3F
`define MISC_MASK_RST       1'b1

// timer_ctrl_reg fields
`define TIMER_CTRL_REQ_BIT  7
`define TIMER_CTRL_MASK_BIT 6
`define TIMER_CTRL_CLR_BIT  3
`define TIMER_CTRL_MASK_RST 1'b1
`define TIMER_CTRL_LOW_RST  6'h00

// port D bit carrying the second request line
`define PORT_D_LINE_BIT   6

// handler vectors, first byte of each pair
`define VEC_RESET         12'hFFE
`define VEC_TRAP          12'hFFC
`define VEC_EXT           12'hFFA
`define VEC_TIMER         12'hFF8

// entry sequence length in instruction cycle periods
`define ENTRY_CYCLES      4'd11
// core clocks per instruction cycle period (oscillator / 4)
`define CLKS_PER_CYCLE    4

`endif

// [logic/mcu_interrupt_sequencer.v]
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "irq_seq_defines.vh"

// Behaviour
// - four sources: pin, timer, second pin, trap
// - finish instruction, stack, set mask, vector, run
// - entry sequence ends on the eleventh cycle period enable
// - trap return restores stacked mask state
// - fixed vector pairs per source
// - trap first when masked, else pin, timer, trap
// - arbitrate only pending requests at boundary
// - masked hardware requests stay latched for later
// - timer and second pin share one vector
// - misc and timer request flags clear only by writing zero; the pin request clears on entry
// - synchronise pins, latch on falling edge
// - misc bit 7 set by edge, sticky
// - misc bit 6 masks second pin, reset one
// - misc bits five to zero read ones
// - second pin readable at port bit 6
// - set flags start entry when mask clear
// - trap enters handler regardless of mask
// - pin level available for branch testing
// - reset uses vector mechanism, highest priority
// - timer flag on zero, mask set by reset
module mcu_interrupt_sequencer #(
  parameter CLKS_PER_CYCLE = `CLKS_PER_CYCLE
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // request sources
  input  wire        ext_req_n_in,
  input  wire        second_edge_request_line_in,
  input  wire [7:0]  port_d_in,
  input  wire        timer_zero_in,
  // processor core handshake
  input  wire        instr_boundary_in,
  input  wire        soft_trap_op_in,
  input  wire        trap_return_op_in,
  input  wire        stacked_mask_in,
  input  wire        mask_set_op_in,
  input  wire        mask_clear_op_in,
  output wire        entry_busy_out,
  output wire        entry_done_out,
  output wire [11:0] vector_addr_out,
  output wire        global_mask_out,
  output wire        ext_level_out,
  output wire [7:0]  timer_ctrl_out,
  output wire        prescaler_clear_out
);

  localparam         ST_IDLE      = 1'b0;
  localparam         ST_ENTRY     = 1'b1;
  localparam integer DIV_LAST_INT = CLKS_PER_CYCLE - 1;
  localparam [3:0]   DIV_LAST     = DIV_LAST_INT[3:0];
  localparam [3:0]   ENTRY_LAST   = `ENTRY_CYCLES - 4'd1;

  // read mux selects
  localparam [1:0] SEL_NONE  = 2'd0;
  localparam [1:0] SEL_MISC  = 2'd1;
  localparam [1:0] SEL_TIMER = 2'd2;
  localparam [1:0] SEL_PORT  = 2'd3;

  reg        state_reg;
  reg [3:0]  div_reg;
  reg        cyc_en_reg;
  reg [3:0]  entry_cnt_reg;
  reg        done_reg;
  reg [11:0] vector_reg;
  reg        imask_reg;
  reg        ext_pend_reg;
  reg        misc_req_reg;
  reg        misc_mask_reg;
  reg        timer_flag_reg;
  reg        timer_mask_reg;
  reg [5:0]  timer_low_reg;
  reg        psc_clear_reg;
  reg [31:0] prdata_reg;
  reg        pready_reg;
  reg        pslverr_reg;
  reg        ext_level_reg;
  reg [7:0]  timer_ctrl_out_reg;
  reg [1:0]  rd_sel;
  reg [7:0]  rd_byte;
  reg        rd_err;

  // pins: [0] external, [1] second line
  wire [1:0] pin_raw;
  wire [1:0] pin_fall;
  wire [1:0] pin_level;

  assign pin_raw = {second_edge_request_line_in, ext_req_n_in};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_sync
      reg sync1_reg;
      reg sync2_reg;
      reg sync3_reg;
      // reset to the idle level so release gives no false edge
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          sync1_reg <= 1'b1;
          sync2_reg <= 1'b1;
          sync3_reg <= 1'b1;
        end else begin
          sync1_reg <= pin_raw[g];
          sync2_reg <= sync1_reg;
          sync3_reg <= sync2_reg;
        end
      end
      // the first stage may be metastable, so nothing else reads it
      assign pin_level[g] = sync2_reg;
      assign pin_fall[g]  = sync3_reg & ~sync2_reg;
    end
  endgenerate

  // apb decode
  wire setup;
  wire access;
  wire wr_acc;
  wire hit_misc;
  wire hit_timer;
  wire hit_port;
  wire wr_misc;
  wire wr_timer;

  assign setup     = psel_in & ~penable_in;
  assign access    = psel_in & penable_in & pready_reg;
  assign wr_acc    = access & pwrite_in & ~pslverr_reg;
  assign hit_misc  = paddr_in == `MISC_EDGE_ADDR;
  assign hit_timer = paddr_in == `TIMER_CTRL_ADDR;
  assign hit_port  = paddr_in == `PORT_D_ADDR;
  assign wr_misc   = wr_acc & hit_misc;
  assign wr_timer  = wr_acc & hit_timer;

  // register read views
  wire [7:0] misc_view;
  wire [7:0] timer_view;
  wire [7:0] port_view;

  assign misc_view  = {misc_req_reg, misc_mask_reg, `MISC_UNUSED_VAL};
  // prescaler clear is write-only and reads zero
  assign timer_view = {timer_flag_reg, timer_mask_reg, timer_low_reg[5:4],
                       1'b0, timer_low_reg[2:0]};
  assign port_view  = {port_d_in[7], pin_level[1], port_d_in[5:0]};

  // pending sources
  wire timer_pend;
  wire misc_pend;
  wire shared_pend;
  wire hw_pend;
  wire take_ok;
  wire take_hw;
  wire take_trap;
  wire take_ext;
  wire take_any;

  assign timer_pend  = timer_flag_reg & ~timer_mask_reg;
  assign misc_pend   = misc_req_reg & ~misc_mask_reg;
  assign shared_pend = timer_pend | misc_pend;
  assign hw_pend     = ext_pend_reg | shared_pend;
  assign take_ok     = (state_reg == ST_IDLE) & instr_boundary_in;
  // unmasked hardware beats a trap that is only the next instruction
  assign take_hw     = take_ok & ~imask_reg & hw_pend;
  assign take_trap   = take_ok & soft_trap_op_in & ~take_hw;
  assign take_ext    = take_hw & ext_pend_reg;
  assign take_any    = take_hw | take_trap;

  // instruction cycle period enable
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      div_reg    <= 4'h0;
      cyc_en_reg <= 1'b0;
    end else begin
      cyc_en_reg <= div_reg == DIV_LAST;
      if (div_reg == DIV_LAST) begin
        div_reg <= 4'h0;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end

  // entry sequencer; reset itself enters through its vector
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg     <= ST_ENTRY;
      vector_reg    <= `VEC_RESET;
      entry_cnt_reg <= 4'h0;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take_any) begin
            state_reg     <= ST_ENTRY;
            entry_cnt_reg <= 4'h0;
            if (take_trap) begin
              vector_reg <= `VEC_TRAP;
            end else if (take_ext) begin
              vector_reg <= `VEC_EXT;
            end else begin
              vector_reg <= `VEC_TIMER;
            end
          end
        end
        ST_ENTRY: begin
          if (cyc_en_reg) begin
            if (entry_cnt_reg == ENTRY_LAST) begin
              state_reg <= ST_IDLE;
              done_reg  <= 1'b1;
            end else begin
              entry_cnt_reg <= entry_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // global mask flag
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      imask_reg <= 1'b1;
    end else if (take_any) begin
      imask_reg <= 1'b1;
    end else if (trap_return_op_in & (state_reg == ST_IDLE)) begin
      imask_reg <= stacked_mask_in;
    end else if (mask_set_op_in) begin
      imask_reg <= 1'b1;
    end else if (mask_clear_op_in) begin
      imask_reg <= 1'b0;
    end
  end

  // external request: held while masked, dropped once accepted; an edge wins
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ext_pend_reg <= 1'b0;
    end else if (pin_fall[0]) begin
      ext_pend_reg <= 1'b1;
    end else if (take_ext) begin
      ext_pend_reg <= 1'b0;
    end
  end

  // second line request: sticky until software writes zero; an edge wins
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      misc_req_reg <= 1'b0;
    end else if (pin_fall[1]) begin
      misc_req_reg <= 1'b1;
    end else if (wr_misc & ~pwdata_in[`MISC_REQ_BIT]) begin
      misc_req_reg <= 1'b0;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      misc_mask_reg <= `MISC_MASK_RST;
    end else if (wr_misc) begin
      misc_mask_reg <= pwdata_in[`MISC_MASK_BIT];
    end
  end

  // timer request: not cleared by entry, the handler must clear it
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      timer_flag_reg <= 1'b0;
    end else if (timer_zero_in) begin
      timer_flag_reg <= 1'b1;
    end else if (wr_timer & ~pwdata_in[`TIMER_CTRL_REQ_BIT]) begin
      timer_flag_reg <= 1'b0;
    end
  end

  // low bits are software mode only
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      timer_mask_reg <= `TIMER_CTRL_MASK_RST;
      timer_low_reg  <= `TIMER_CTRL_LOW_RST;
    end else if (wr_timer) begin
      timer_mask_reg <= pwdata_in[`TIMER_CTRL_MASK_BIT];
      timer_low_reg  <= pwdata_in[5:0];
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      psc_clear_reg <= 1'b0;
    end else begin
      psc_clear_reg <= wr_timer & pwdata_in[`TIMER_CTRL_CLR_BIT];
    end
  end

  always @* begin
    rd_sel = SEL_NONE;
    if (hit_misc) begin
      rd_sel = SEL_MISC;
    end else if (hit_timer) begin
      rd_sel = SEL_TIMER;
    end else if (hit_port) begin
      rd_sel = SEL_PORT;
    end
  end

  // port D is input only, so a write there is refused
  always @* begin
    rd_byte = 8'h00;
    rd_err  = 1'b0;
    case (rd_sel)
      SEL_MISC: begin
        rd_byte = misc_view;
      end
      SEL_TIMER: begin
        rd_byte = timer_view;
      end
      SEL_PORT: begin
        rd_byte = port_view;
        rd_err  = pwrite_in;
      end
      default: begin
        rd_byte = 8'h00;
        rd_err  = 1'b1;
      end
    endcase
  end

  // apb: no wait state, read data captured in setup
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= rd_err;
        prdata_reg  <= {24'h000000, rd_byte};
      end else if (access) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ext_level_reg      <= 1'b1;
      timer_ctrl_out_reg <= 8'h00;
    end else begin
      ext_level_reg      <= pin_level[0];
      timer_ctrl_out_reg <= timer_view;
    end
  end

  assign prdata_out          = prdata_reg;
  assign pready_out          = pready_reg;
  assign pslverr_out         = pslverr_reg;
  assign entry_busy_out      = state_reg;
  assign entry_done_out      = done_reg;
  assign vector_addr_out     = vector_reg;
  assign global_mask_out     = imask_reg;
  assign ext_level_out       = ext_level_reg;
  assign timer_ctrl_out      = timer_ctrl_out_reg;
  assign prescaler_clear_out = psc_clear_reg;

endmodule

// [verif/irq_seq_asserts.sv]
`timescale 1ns/10ps
`include "irq_seq_defines.vh"
module irq_seq_asserts #(
  parameter CLKS_PER_CYCLE = 4
) (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire        pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        instr_boundary_in,
  input wire        soft_trap_op_in,
  input wire        entry_busy_out,
  input wire        entry_done_out,
  input wire [11:0] vector_addr_out,
  input wire        global_mask_out
);
  // window is wide because the cycle enable phase is free-running
  localparam int LO = 10 * CLKS_PER_CYCLE;
  localparam int HI = 11 * CLKS_PER_CYCLE;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  chk_entry_len: assert property (
    $rose(entry_busy_out) |-> ##[LO:HI] entry_done_out)
    else $error("entry length wrong");
  chk_done_pulse: assert property (entry_done_out |=> !entry_done_out)
    else $error("done not a pulse");
  chk_busy_mask: assert property ($rose(entry_busy_out) |-> global_mask_out)
    else $error("mask not set at entry");
  chk_end_done: assert property ($fell(entry_busy_out) |-> entry_done_out)
    else $error("entry ended without done");
  chk_vec_hold: assert property (
    entry_busy_out && $past(entry_busy_out) |-> $stable(vector_addr_out))
    else $error("vector moved in entry");
  chk_trap_vec: assert property (
    instr_boundary_in && soft_trap_op_in && global_mask_out && !entry_busy_out
    |=> entry_busy_out && vector_addr_out == `VEC_TRAP)
    else $error("masked trap not taken");
  chk_no_stray: assert property (
    !entry_busy_out && !instr_boundary_in |=> !entry_busy_out)
    else $error("entry off boundary");
  chk_mask_hold: assert property (
    global_mask_out && instr_boundary_in && !soft_trap_op_in && !entry_busy_out
    |=> !entry_busy_out)
    else $error("entry while masked");
  chk_unused_ones: assert property (
    pready_out && !pwrite_in && paddr_in == `MISC_EDGE_ADDR |->
    prdata_out[5:0] == `MISC_UNUSED_VAL)
    else $error("unused bits not ones");
endmodule

bind mcu_interrupt_sequencer irq_seq_asserts #(.CLKS_PER_CYCLE(CLKS_PER_CYCLE)) u_chk (
  .core_clk_in, .rst_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
  .instr_boundary_in, .soft_trap_op_in, .entry_busy_out, .entry_done_out,
  .vector_addr_out, .global_mask_out);

// [verif/core_model.sv]
`timescale 1ns/10ps
module core_model (
  input  wire       core_clk_in,
  input  wire       rst_in,
  input  wire       busy_in,
  input  wire [2:0] gap_in,
  output reg        boundary_out
);
  reg [2:0] cnt_reg;
  // boundary only between instructions, never inside entry
  always @(posedge core_clk_in) begin
    if (rst_in || busy_in || cnt_reg >= gap_in) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
    boundary_out <= !rst_in && !busy_in && cnt_reg >= gap_in;
  end
endmodule

// [verif/mcu_interrupt_sequencer_tb_top.sv]
`timescale 1ns/10ps
`include "irq_seq_defines.vh"
module mcu_interrupt_sequencer_tb_top;
  logic core_clk_in, rst_in, psel_in, penable_in, pwrite_in, ext_req_n_in, pready_out;
  logic second_edge_request_line_in, timer_zero_in, instr_boundary_in, soft_trap_op_in;
  logic trap_return_op_in, stacked_mask_in, mask_set_op_in, mask_clear_op_in, pslverr_out;
  logic entry_busy_out, entry_done_out, global_mask_out, ext_level_out, prescaler_clear_out;
  logic [11:0] paddr_in, vector_addr_out;
  logic [31:0] pwdata_in, prdata_out;
  logic [7:0]  port_d_in, timer_ctrl_out, r;
  logic [2:0]  gap;
  int          fails, checks, psc_seen;
  logic [11:0] vq[$];
  logic [32:0] rq[$];
  mcu_interrupt_sequencer #(.CLKS_PER_CYCLE(4)) DUT (.*);
  core_model core (.core_clk_in, .rst_in, .busy_in(entry_busy_out), .gap_in(gap),
    .boundary_out(instr_boundary_in));
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  task check(input string n, input logic [32:0] s, input logic [32:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    @(posedge core_clk_in) penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task entered(input logic [11:0] v);
    vq.push_back(v);
    @(posedge core_clk_in iff entry_done_out === 1'b1);
  endtask
  task ret;
    trap_return_op_in <= 1'b1;
    stacked_mask_in <= 1'b0;
    tick(1);
    trap_return_op_in <= 1'b0;
  endtask
  always @(posedge core_clk_in) begin
    if (entry_done_out === 1'b1)
      check("vector", vector_addr_out, vq.size() ? vq.pop_front() : 12'h000);
    if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
      check("read", {pslverr_out, prdata_out}, rq.size() ? rq.pop_front() : 33'h0);
    if (prescaler_clear_out === 1'b1)
      psc_seen++;
  end
  initial begin
    #40000;
    fails++;
    test_done;
  end
  initial begin
    {psel_in, penable_in, pwrite_in, timer_zero_in, soft_trap_op_in} = 5'h00;
    {trap_return_op_in, stacked_mask_in, mask_set_op_in, mask_clear_op_in} = 4'h0;
    {ext_req_n_in, second_edge_request_line_in, rst_in} = 3'h7;
    paddr_in = 12'h000;
    pwdata_in = 32'h00000000;
    port_d_in = 8'h00;
    gap = 3'h1;
    r = $urandom(32'h9622);
    tick(10);
    rst_in <= 1'b0;
    entered(`VEC_RESET);
    rd(`MISC_EDGE_ADDR, 33'h07F);
    rd(`TIMER_CTRL_ADDR, 33'h040);
    rd(12'h030, 33'h100000000);
    $display("test reset done");
    mask_clear_op_in <= 1'b1;
    tick(1);
    mask_clear_op_in <= 1'b0;
    ext_req_n_in <= 1'b0;
    entered(`VEC_EXT);
    check("level", ext_level_out, 33'h0);
    check("mask", global_mask_out, 33'h1);
    ext_req_n_in <= 1'b1;
    $display("test pin done");
    apb(1'b1, `MISC_EDGE_ADDR, 8'h00);
    second_edge_request_line_in <= 1'b0;
    tick(6);
    rd(`MISC_EDGE_ADDR, 33'h0BF);
    soft_trap_op_in <= 1'b1;
    @(posedge core_clk_in iff entry_busy_out === 1'b1);
    soft_trap_op_in <= 1'b0;
    entered(`VEC_TRAP);
    ret;
    tick(1);
    check("mask", global_mask_out, 33'h0);
    entered(`VEC_TIMER);
    second_edge_request_line_in <= 1'b1;
    apb(1'b1, `MISC_EDGE_ADDR, 8'h80);
    rd(`MISC_EDGE_ADDR, 33'h0BF);
    apb(1'b1, `MISC_EDGE_ADDR, 8'h40);
    rd(`MISC_EDGE_ADDR, 33'h07F);
    $display("test second line done");
    // random pins; a falling line only sets the masked flag here
    repeat (3) begin
      r = $urandom;
      port_d_in <= r;
      second_edge_request_line_in <= r[6];
      gap <= r[2:0] | 3'h1;
      tick(4);
      rd(`PORT_D_ADDR, {25'h0, r});
    end
    second_edge_request_line_in <= 1'b1;
    apb(1'b1, `MISC_EDGE_ADDR, 8'h40);
    $display("test port done");
    timer_zero_in <= 1'b1;
    tick(1);
    timer_zero_in <= 1'b0;
    tick(1);
    rd(`TIMER_CTRL_ADDR, 33'h0C0);
    apb(1'b1, `TIMER_CTRL_ADDR, 8'h80);
    ext_req_n_in <= 1'b0;
    gap <= 3'h5;
    tick(6);
    ret;
    entered(`VEC_EXT);
    ext_req_n_in <= 1'b1;
    ret;
    entered(`VEC_TIMER);
    apb(1'b1, `TIMER_CTRL_ADDR, 8'h40);
    rd(`TIMER_CTRL_ADDR, 33'h040);
    // a one in the request bit must not set it; bit 3 pulses the clear
    apb(1'b1, `TIMER_CTRL_ADDR, 8'hFF);
    rd(`TIMER_CTRL_ADDR, 33'h077);
    check("timer view", timer_ctrl_out, 33'h077);
    check("clear pulses", psc_seen, 33'h1);
    $display("test priority done");
    check("pending", vq.size(), 33'h0);
    test_done;
  end
endmodule
